// file: rtl/led_blink_pattern_generator.sv
// Purpose: programmable twelve slot LED flash pattern
// Assumes: byte register port in the core clock domain
// Notes: a register write reaches the LED in the next cycle; slot ends are free running
`timescale 1ns/1ps
`include "blink_defs.svh"
module led_blink_pattern_generator (
	input  wire logic       clk,       // Core clock, 25 MHz
	input  wire logic       rst,       // Async reset, high
	input  wire logic [7:0] reg_addr,  // Register address
	input  wire logic       reg_wr,    // Write strobe
	input  wire logic       reg_rd,    // Read strobe
	input  wire logic [7:0] reg_wdata, // Write data
	output logic      [7:0] reg_rdata, // Read data, one cycle after strobe
	output logic            led_on     // LED drive, high is on
);
	// ==========================================================
	// State
	blink_pkg::gen_state_t st;
	blink_pkg::gen_state_t next_st;
	logic                  tick;
	logic [11:0]           pattern;

	function automatic logic [3:0] last_index(input logic [1:0] sel);
		case (sel)
			2'h0: last_index = `LAST_12;
			2'h1: last_index = `LAST_10;
			2'h2: last_index = `LAST_9;
			default: last_index = `LAST_8;
		endcase
	endfunction

	// ==========================================================
	// Slot timing
	slot_timer u_timer (
		.clk   (clk),
		.rst   (rst),
		.width (st.pattern_cfg[`CFG_WIDTH_HI:`CFG_WIDTH_LO]),
		.tick  (tick)
	);

	// ==========================================================
	// Pattern train
	// Low byte first, then the config nibble
	function automatic logic [11:0] train_bits(input blink_pkg::gen_state_t s);
		train_bits = {s.pattern_cfg[`CFG_NIB_HI:`CFG_NIB_LO], s.pattern_low};
	endfunction

	function automatic logic train_bit(input blink_pkg::gen_state_t s, input logic [3:0] idx);
		logic [11:0] bits;
		bits      = train_bits(s);
		train_bit = bits[idx];
	endfunction

	assign pattern = train_bits(st);

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		if (reg_wr && reg_addr == `PATTERN_LOW_ADDR) begin
			next_st.pattern_low = reg_wdata;
		end
		if (reg_wr && reg_addr == `PATTERN_CFG_ADDR) begin
			next_st.pattern_cfg = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				`PATTERN_LOW_ADDR: next_st.rdata = st.pattern_low;
				`PATTERN_CFG_ADDR: next_st.rdata = st.pattern_cfg;
				default: next_st.rdata = `REG_RESET;
			endcase
		end
		if (tick) begin
			// Shortening the length past the current index also wraps
			if (st.index >= last_index(st.pattern_cfg[`CFG_LEN_HI:`CFG_LEN_LO])) begin
				next_st.index = 4'h0;
			end else begin
				next_st.index = st.index + 4'h1;
			end
		end
		// Taken from the next register values so a write reaches the LED with the register
		next_st.led = train_bit(next_st, next_st.index);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign led_on    = st.led;

	// ==========================================================
	// Checks: LED drive
	// The drive follows the live registers, so a write shows on the LED in the same cycle as in the register
	a_led_follows_bit: assert property (
		@(posedge clk) disable iff (rst)
		led_on == pattern[st.index]
	) else $error("led differs from pattern");

	// Slots 0 to 7 come from the low byte, bit 0 first
	a_low_first: assert property (
		@(posedge clk) disable iff (rst)
		st.index <= `LAST_8 |-> led_on == st.pattern_low[st.index[2:0]]
	) else $error("low byte bit wrong");

	// Slots 8 to 11 come from the config nibble, bit 0 first
	a_nibble_last: assert property (
		@(posedge clk) disable iff (rst)
		st.index > `LAST_8 |-> led_on == st.pattern_cfg[st.index[1:0]]
	) else $error("nibble bit wrong");

	// With no slot end and no write the LED stands for the whole slot
	a_led_holds: assert property (
		@(posedge clk) disable iff (rst)
		(!tick && !reg_wr) |=> $stable(led_on)
	) else $error("led moved inside a slot");

	// ==========================================================
	// Checks: slot index
	// Slot ends come only after a million or more cycles, so the wrap and step checks and the
	// wrap covers are reached only in long runs
	// Twelve slots at most, whatever the length field says
	a_index_bounded: assert property (
		@(posedge clk) disable iff (rst)
		st.index <= `LAST_12
	) else $error("index past twelve slots");

	// The last slot of the chosen length returns to slot 0; a shortened
	// length also wraps when the index already stands beyond it
	a_index_wraps: assert property (
		@(posedge clk) disable iff (rst)
		(tick && st.index >= last_index(st.pattern_cfg[`CFG_LEN_HI:`CFG_LEN_LO]))
			|=> st.index == 4'h0
	) else $error("no wrap at end");

	// Every other slot end moves on by exactly one
	a_index_steps: assert property (
		@(posedge clk) disable iff (rst)
		(tick && st.index < last_index(st.pattern_cfg[`CFG_LEN_HI:`CFG_LEN_LO]))
			|=> st.index == $past(st.index) + 4'h1
	) else $error("index did not advance");

	// Only a slot end may move the index
	a_index_holds: assert property (
		@(posedge clk) disable iff (rst)
		!tick |=> $stable(st.index)
	) else $error("index moved without tick");

	// ==========================================================
	// Checks: register port
	// A write lands at the edge that takes it
	a_low_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == `PATTERN_LOW_ADDR) |=> st.pattern_low == $past(reg_wdata)
	) else $error("low pattern write lost");

	// The config write also retimes the current slot; a shortened length takes effect at the next slot end
	a_cfg_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr == `PATTERN_CFG_ADDR) |=> st.pattern_cfg == $past(reg_wdata)
	) else $error("config write lost");

	// Writes to any other address leave both registers alone
	a_odd_write_ignored: assert property (
		@(posedge clk) disable iff (rst)
		(reg_wr && reg_addr != `PATTERN_LOW_ADDR && reg_addr != `PATTERN_CFG_ADDR)
			|=> $stable(st.pattern_low) && $stable(st.pattern_cfg)
	) else $error("stray write changed a register");

	// A read returns the value held before a write in the same cycle
	a_read_back: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr == `PATTERN_LOW_ADDR) |=> reg_rdata == $past(st.pattern_low)
	) else $error("readback wrong");

	// Config reads back whole, width and length fields included
	a_cfg_read_back: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr == `PATTERN_CFG_ADDR) |=> reg_rdata == $past(st.pattern_cfg)
	) else $error("config readback wrong");

	// Other addresses read as zero, so a stray read never echoes pattern bits
	a_odd_read_zero: assert property (
		@(posedge clk) disable iff (rst)
		(reg_rd && reg_addr != `PATTERN_LOW_ADDR && reg_addr != `PATTERN_CFG_ADDR)
			|=> reg_rdata == `REG_RESET
	) else $error("stray read not zero");

	// ==========================================================
	// Covers
	// Full twelve slot train ends and wraps
	c_wrap: cover property (
		@(posedge clk) disable iff (rst)
		tick && st.index == `LAST_12
	);

	// Shortest train ends on slot 7
	c_len8: cover property (
		@(posedge clk) disable iff (rst)
		tick && st.index == `LAST_8 && st.pattern_cfg[`CFG_LEN_HI:`CFG_LEN_LO] == `LEN_SEL_8
	);

	// LED lights
	c_led_on: cover property (
		@(posedge clk) disable iff (rst)
		$rose(led_on)
	);

	// LED goes dark
	c_led_off: cover property (
		@(posedge clk) disable iff (rst)
		$fell(led_on)
	);

	// Write and read of one register in the same cycle
	c_write_read: cover property (
		@(posedge clk) disable iff (rst)
		reg_wr && reg_rd && reg_addr == `PATTERN_LOW_ADDR
	);
endmodule // led_blink_pattern_generator

// file: rtl/blink_defs.svh
// Purpose: constants for the LED blink pattern generator
// Assumes: 25 MHz core clock
// Notes: register offsets, field positions and slot timing counts
// Function
// - Bits 7:0 of the low pattern register are emitted first, bit 0 to bit 7, one slot each.
// - A one in the current pattern bit turns the LED on and a zero turns it off.
// - Bits 3:0 of the config register are the upper four pattern bits, sent after the low eight.
// - Config bits 7:6 pick the slot width: 41.67, 55.55, 83.33 or 125 ms.
// - Config bits 5:4 pick the length 12, 10, 9 or 8 bits, after which the pattern wraps to bit 0.
`ifndef BLINK_DEFS_SVH
`define BLINK_DEFS_SVH

// ==========================================================
// Register map
`define PATTERN_LOW_ADDR   8'h74
`define PATTERN_CFG_ADDR   8'h75
`define REG_RESET          8'h00

// ==========================================================
// Config fields
`define CFG_WIDTH_HI       7
`define CFG_WIDTH_LO       6
`define CFG_LEN_HI         5
`define CFG_LEN_LO         4
`define CFG_NIB_HI         3
`define CFG_NIB_LO         0

// ==========================================================
// Timing: slot widths in microseconds, core clocks per microsecond
// Kept as 32 bit unsigned so that the longest slot product cannot overflow
`define CLK_PER_US         32'h00000019
`define SLOT_US_0          32'h0000a2c6
`define SLOT_US_1          32'h0000d8fe
`define SLOT_US_2          32'h00014582
`define SLOT_US_3          32'h0001e848
// Cycle counts per slot; every width is a whole number of microseconds
`define SLOT_CYC(us)       ((us) * `CLK_PER_US)

// ==========================================================
// Pattern lengths: index of last slot
`define LAST_12            4'hb
`define LAST_10            4'h9
`define LAST_9             4'h8
`define LAST_8             4'h7
`define LEN_SEL_8          2'h3

`endif

// file: rtl/blink_pkg.sv
// Purpose: types for the LED blink pattern generator
// Assumes: nothing beyond the defs header
// Notes: state is carried as packed structs
package blink_pkg;
	typedef struct packed {
		logic [21:0] count;
		logic        tick;
	} timer_state_t;

	typedef struct packed {
		logic [7:0] pattern_low;
		logic [7:0] pattern_cfg;
		logic [3:0] index;
		logic       led;
		logic [7:0] rdata;
	} gen_state_t;
endpackage

// file: rtl/slot_timer.sv
// Purpose: slot period counter
// Assumes: width select from the same clock domain
// Notes: tick pulses one cycle at the end of each slot
`timescale 1ns/1ps
`include "blink_defs.svh"
module slot_timer (
	input  wire logic       clk,     // Core clock
	input  wire logic       rst,     // Async reset, high
	input  wire logic [1:0] width,   // Slot width select
	output logic            tick     // Slot end pulse
);
	blink_pkg::timer_state_t st;
	blink_pkg::timer_state_t next_st;

	function automatic logic [21:0] slot_last(input logic [1:0] sel);
		case (sel)
			2'h0: slot_last = 22'(`SLOT_CYC(`SLOT_US_0) - 1);
			2'h1: slot_last = 22'(`SLOT_CYC(`SLOT_US_1) - 1);
			2'h2: slot_last = 22'(`SLOT_CYC(`SLOT_US_2) - 1);
			default: slot_last = 22'(`SLOT_CYC(`SLOT_US_3) - 1);
		endcase
	endfunction

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		// A width change mid slot ends the slot at once if already past the new end
		if (st.count >= slot_last(width)) begin
			next_st.count = 22'h0;
			next_st.tick  = 1'b1;
		end else begin
			next_st.count = st.count + 22'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;

	a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
		st.tick |-> st.count == 22'h0 && !$past(st.tick)) else $error("tick without restart");
endmodule // slot_timer

// file: tb/led_indicator.sv
// Purpose: LED on an output pin, far side of the pattern generator
// Assumes: active high drive, no sync pin in use
// Notes: counts lit cycles so a stuck drive shows up
`timescale 1ns/1ps
module led_indicator (
	input  wire logic        clk,       // Core clock
	input  wire logic        led_on,    // Drive from the generator
	output logic             lit,       // Light seen by the user
	output logic      [31:0] lit_count  // Cycles spent lit
);
	// The lamp has no memory: a high drive is light, low is dark
	logic [31:0] count = 32'h0;
	assign lit       = led_on;
	assign lit_count = count;
	always @(posedge clk) begin
		if (led_on === 1'b1) begin
			count <= count + 32'h1;
		end
	end
endmodule // led_indicator

// file: tb/testbench.sv
// Purpose: self-checking bench for the LED pattern generator
// Assumes: slot periods exceed the run, so slot 0 stays current
// Notes: read results are checked off a queue by a monitor
`timescale 1ns/1ps
`include "blink_defs.svh"
module testbench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_wdata = 8'h0;
	logic [7:0]  reg_rdata;
	logic        led_on;
	logic        lit;
	logic [31:0] lit_count;
	logic        rd_d = 1'b0;
	logic [31:0] rnd = 32'h9105;
	logic [7:0]  d;
	logic [7:0]  exq[$];
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;
	always #20 clk = ~clk;
	led_blink_pattern_generator led_blink_pattern_generator_i (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .led_on(led_on));
	led_indicator led_indicator_i (.clk(clk), .led_on(led_on), .lit(lit), .lit_count(lit_count));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// One register cycle; a read leaves its expected answer on the queue
	task automatic acc(input logic w, input logic r, input logic [7:0] a,
			input logic [7:0] wd, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_wr <= w;
		reg_rd <= r;
		reg_wdata <= wd;
		if (r) exq.push_back(e);
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	// LED level, then one lamp cycle counted exactly when it is lit
	task automatic led_is(input logic e);
		logic [31:0] lit_was;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check({7'h0, lit}, {7'h0, e});
		lit_was = lit_count;
		@(negedge clk);
		check(8'(lit_count - lit_was), {7'h0, e});
	endtask
	// ==========================================================
	// Monitor: read data stands from the edge after the strobe
	always @(posedge clk) rd_d <= reg_rd;
	always @(negedge clk) begin
		if (rd_d) begin
			// A read with no note is always a mismatch
			if (exq.size() == 0) check(8'h00, 8'hff);
			else check(reg_rdata, exq.pop_front());
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			test_done();
		end
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		acc(1'b0, 1'b1, `PATTERN_LOW_ADDR, 8'h0, `REG_RESET);
		acc(1'b0, 1'b1, `PATTERN_CFG_ADDR, 8'h0, `REG_RESET);
		led_is(1'b0);
		$display("reset test done");
		// Eight random low and config patterns, each written, read back and
		// checked on the LED while slot 0 stays current
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			d = rnd[7:0];
			acc(1'b1, 1'b0, `PATTERN_LOW_ADDR, d, 8'h0);
			// Same-cycle write and read must return the older value
			acc(1'b1, 1'b1, `PATTERN_LOW_ADDR, ~d, d);
			acc(1'b0, 1'b1, `PATTERN_LOW_ADDR, 8'h0, ~d);
			led_is(~d[0]);
			acc(1'b1, 1'b0, `PATTERN_CFG_ADDR, rnd[15:8], 8'h0);
			acc(1'b0, 1'b1, `PATTERN_CFG_ADDR, 8'h0, rnd[15:8]);
			led_is(~d[0]);
		end
		$display("pattern register test done");
		acc(1'b1, 1'b0, 8'h76, rnd[23:16], 8'h0);
		acc(1'b0, 1'b1, 8'h76, 8'h0, 8'h00);
		acc(1'b0, 1'b1, 8'h73, 8'h0, 8'h00);
		acc(1'b0, 1'b1, `PATTERN_LOW_ADDR, 8'h0, ~d);
		acc(1'b0, 1'b1, `PATTERN_CFG_ADDR, 8'h0, rnd[15:8]);
		repeat (3) @(posedge clk);
		$display("unmapped address test done");
		// Reset in mid run: both registers and the LED return to zero
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		acc(1'b0, 1'b1, `PATTERN_LOW_ADDR, 8'h0, `REG_RESET);
		acc(1'b0, 1'b1, `PATTERN_CFG_ADDR, 8'h0, `REG_RESET);
		led_is(1'b0);
		repeat (3) @(posedge clk);
		$display("mid-run reset test done");
		check({7'h0, exq.size() == 0}, 8'h01);
		test_done();
	end
endmodule // testbench
